// >>> core/aqb_pkg.sv
// constants, field layouts and carrier types of the per-axis register bank
package aqb_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int AXES = 4;
    localparam int REGS = 48;
    localparam int PRE = 13;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] CMD_WR_PRE_BASE = 8'h80;
    localparam logic [7:0] CMD_WR_PRE_LAST = 8'h8C;
    localparam logic [7:0] CMD_WR_WORK_BASE = 8'h90;
    localparam logic [7:0] CMD_WR_WORK_LAST = 8'hBC;
    localparam logic [7:0] CMD_RD_PRE_BASE = 8'hC0;
    localparam logic [7:0] CMD_RD_PRE_LAST = 8'hCC;
    localparam logic [7:0] CMD_RD_WORK_BASE = 8'hD0;
    localparam logic [7:0] CMD_PRE_CANCEL = 8'h26;
    localparam logic [7:0] CMD_STOP_DECEL = 8'h49;
    localparam logic [7:0] CMD_STOP_IMMED = 8'h4A;
    localparam logic [7:0] CMD_START = 8'h51;

    // ****************************************
    // register indices (code minus base)
    // ****************************************
    localparam logic [5:0] IDX_MODE = 6'h07;
    localparam logic [5:0] IDX_DEFL_COUNT = 6'h15;
    localparam logic [5:0] IDX_CMP5 = 6'h1B;
    localparam logic [5:0] IDX_IRQ_CAUSE = 6'h1C;
    localparam logic [5:0] IDX_CMD_LATCH = 6'h1D;
    localparam logic [5:0] IDX_MECH_LATCH = 6'h1E;
    localparam logic [5:0] IDX_DEFL_LATCH = 6'h1F;
    localparam logic [5:0] IDX_GEN_LATCH = 6'h20;
    localparam logic [5:0] IDX_EXT_STATUS = 6'h21;
    localparam logic [5:0] IDX_ERR_STATUS = 6'h22;
    localparam logic [5:0] IDX_EVT_STATUS = 6'h23;
    localparam logic [5:0] IDX_RESIDUAL = 6'h24;
    localparam logic [5:0] IDX_SPEED_MON = 6'h25;
    localparam logic [5:0] IDX_AUTO_SLOWDOWN = 6'h26;
    localparam logic [5:0] IDX_ARC_TOTAL = 6'h2C;
    localparam logic [5:0] IDX_ARC_COUNTER = 6'h2D;
    localparam logic [5:0] IDX_INTERP_STATUS = 6'h2F;
    localparam logic [3:0] PRE_LAST_PLAIN = 4'hA;
    localparam logic [3:0] PRE_CMP5 = 4'hB;
    localparam logic [3:0] PRE_ARC = 4'hC;

    // ****************************************
    // fields, reset values and timing
    // ****************************************
    localparam int FILL_LSB = 16;
    localparam int NEXT_OP_IRQ_BIT = 5;
    localparam int NEXT_OP_EVT_BIT = 5;
    localparam int COMPLETION_SEL_BIT = 6;
    localparam logic [1:0] FILL_NONE = 2'b00;
    localparam logic [1:0] FILL_WORK = 2'b01;
    localparam logic [1:0] FILL_ONE = 2'b10;
    localparam logic [1:0] FILL_TWO = 2'b11;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam int CMD_WAIT_CLKS = 4;
    localparam int PULSE_GAP_CLKS = 15;
    localparam logic [2:0] WAIT_LOAD = 3'(CMD_WAIT_CLKS);

    // ****************************************
    // types
    // ****************************************
    typedef logic [REGS-1:0][31:0] aqb_work_t;
    typedef logic [PRE-1:0][31:0] aqb_pre_t;

    typedef struct packed {
        logic valid;
        logic [1:0] axis;
        logic [7:0] code;
        logic [31:0] data;
    } aqb_cmd_t;

    typedef struct packed {
        logic busy;
        logic move_done;
        logic error_stop;
        logic [31:0] cmd_latch;
        logic [31:0] mech_latch;
        logic [15:0] defl_latch;
        logic [31:0] gen_latch;
        logic [23:0] ext_status;
        logic [31:0] residual;
        logic [22:0] speed_monitor;
        logic [23:0] auto_slowdown;
        logic [31:0] arc_counter;
        logic [23:0] interp_status;
    } aqb_axis_in_t;

    typedef struct packed {
        aqb_pre_t op_work;
        logic completion_timing_select;
        logic [1:0] queue_fill_level;
        logic queue_full_flag;
        logic start;
        logic stop;
    } aqb_axis_out_t;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] reg_mask(input logic [5:0] idx);
        case (idx)
            6'h01, 6'h02, 6'h03, 6'h04, 6'h0B, 6'h15: reg_mask = 32'h0000_FFFF;
            6'h05: reg_mask = 32'h0000_0FFF;
            6'h06: reg_mask = 32'h00FF_FFFF;
            6'h07: reg_mask = 32'h3FFF_FFFF;
            6'h09, 6'h0A: reg_mask = 32'h0000_7FFF;
            6'h10: reg_mask = 32'h0FFF_FFFF;
            6'h1C: reg_mask = 32'h0007_FFFF;
            6'h22: reg_mask = 32'h0003_FFFF;
            6'h23: reg_mask = 32'h000F_FFFF;
            default: reg_mask = 32'hFFFF_FFFF;
        endcase
    endfunction

    function automatic logic writable(input logic [5:0] idx);
        writable = (idx <= IDX_IRQ_CAUSE) || idx == IDX_ERR_STATUS || idx == IDX_EVT_STATUS
            || idx == IDX_ARC_TOTAL;
    endfunction

    function automatic logic [5:0] pre_to_work(input logic [3:0] pi);
        if (pi == PRE_CMP5) begin
            pre_to_work = IDX_CMP5;
        end else if (pi == PRE_ARC) begin
            pre_to_work = IDX_ARC_TOTAL;
        end else begin
            pre_to_work = {2'b00, pi};
        end
    endfunction

endpackage

// >>> core/aqb_axis_bank.sv
// per-axis working registers with two-layer operation pre-register queue
//
// Notes on behaviour
// - every axis has its own full register set
// - target position: 32-bit read/write, queued
// - arc centre / master feed: 32-bit, queued
// - four latch registers read-only; deflection 16-bit
// - operation queue separate from comparator five staging
// - operation queue holds two pending parameter sets
// - queued writes leave running move untouched
// - start commits; unwritten parameters keep old value
// - start while empty loads working, fill 01
// - move done shifts next entry, auto-starts
// - fill level reported in extension status
// - full flag set exactly at fill 11
// - working register write acts immediately
// - next-op cause raises interrupt leaving fill 11
// - pulse completion allows fifteen-clock gap
// - cancel plus stop discards queued entries
// - error stop discards queued entries
// - all registers reset to zero
`timescale 1ns/1ps

module aqb_axis_bank (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire aqb_pkg::aqb_cmd_t cmd_in,
    input wire aqb_pkg::aqb_axis_in_t [aqb_pkg::AXES-1:0] axis_in,
    output aqb_pkg::aqb_axis_out_t [aqb_pkg::AXES-1:0] axis_out,
    output logic [31:0] rd_data_out,
    output logic rd_valid_out,
    output logic wait_request_n_out,
    output logic int_n_out
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        aqb_pkg::aqb_work_t work;
        aqb_pkg::aqb_pre_t stage;
        aqb_pkg::aqb_pre_t q1;
        aqb_pkg::aqb_pre_t q2;
        logic [1:0] fill;
        logic cancel_armed;
        logic start;
        logic stop;
    } aqb_axis_state_t;

    typedef struct packed {
        aqb_axis_state_t [aqb_pkg::AXES-1:0] axis;
        logic [2:0] wait_cnt;
        logic [31:0] rd_data;
        logic rd_valid;
    } aqb_state_t;

    aqb_state_t st;
    aqb_state_t next_st;

    // ****************************************
    // helpers
    // ****************************************
    // queued entry into the working set; comparator five is not part of a move
    function automatic aqb_pkg::aqb_work_t load_ops(input aqb_pkg::aqb_work_t w, input aqb_pkg::aqb_pre_t e);
        aqb_pkg::aqb_work_t r;
        r = w;
        for (int i = 0; i < aqb_pkg::PRE; i++) begin
            if (4'(i) != aqb_pkg::PRE_CMP5) begin
                r[aqb_pkg::pre_to_work(4'(i))] = e[i];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] read_work(input aqb_axis_state_t s, input aqb_pkg::aqb_axis_in_t x,
                                              input logic [5:0] idx);
        logic [31:0] r;
        r = aqb_pkg::REG_RESET;
        case (idx)
            aqb_pkg::IDX_CMD_LATCH: r = x.cmd_latch;
            aqb_pkg::IDX_MECH_LATCH: r = x.mech_latch;
            aqb_pkg::IDX_DEFL_LATCH: r = {16'h0000, x.defl_latch};
            aqb_pkg::IDX_GEN_LATCH: r = x.gen_latch;
            aqb_pkg::IDX_EXT_STATUS: begin
                r = {8'h00, x.ext_status};
                r[aqb_pkg::FILL_LSB +: 2] = s.fill;
            end
            aqb_pkg::IDX_RESIDUAL: r = x.residual;
            aqb_pkg::IDX_SPEED_MON: r = {9'h000, x.speed_monitor};
            aqb_pkg::IDX_AUTO_SLOWDOWN: r = {8'h00, x.auto_slowdown};
            aqb_pkg::IDX_ARC_COUNTER: r = x.arc_counter;
            aqb_pkg::IDX_INTERP_STATUS: r = {8'h00, x.interp_status};
            default: begin
                if (aqb_pkg::writable(idx)) begin
                    r = s.work[idx];
                end
            end
        endcase
        return r;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic accept;
        logic sel;
        logic evt_set;
        logic [7:0] wr_work_off;
        logic [7:0] wr_pre_off;
        logic [7:0] rd_work_off;
        logic [7:0] rd_pre_off;
        logic [5:0] wi;
        logic [3:0] pi;
        logic is_wr_work;
        logic is_wr_pre;
        logic is_rd_work;
        logic is_rd_pre;
        logic is_stop;
        accept = cmd_in.valid && st.wait_cnt == 3'd0;
        sel = 1'b0;
        evt_set = 1'b0;
        wr_work_off = cmd_in.code - aqb_pkg::CMD_WR_WORK_BASE;
        wr_pre_off = cmd_in.code - aqb_pkg::CMD_WR_PRE_BASE;
        rd_work_off = cmd_in.code - aqb_pkg::CMD_RD_WORK_BASE;
        rd_pre_off = cmd_in.code - aqb_pkg::CMD_RD_PRE_BASE;
        is_wr_work = cmd_in.code >= aqb_pkg::CMD_WR_WORK_BASE && cmd_in.code <= aqb_pkg::CMD_WR_WORK_LAST;
        is_wr_pre = cmd_in.code >= aqb_pkg::CMD_WR_PRE_BASE && cmd_in.code <= aqb_pkg::CMD_WR_PRE_LAST;
        is_rd_work = cmd_in.code >= aqb_pkg::CMD_RD_WORK_BASE;
        is_rd_pre = cmd_in.code >= aqb_pkg::CMD_RD_PRE_BASE && cmd_in.code <= aqb_pkg::CMD_RD_PRE_LAST;
        is_stop = cmd_in.code == aqb_pkg::CMD_STOP_DECEL || cmd_in.code == aqb_pkg::CMD_STOP_IMMED;
        wi = 6'h00;
        pi = 4'h0;

        next_st = st;
        next_st.rd_valid = 1'b0;
        // commands arriving during the wait are dropped; the host owes the gap
        if (accept) begin
            next_st.wait_cnt = aqb_pkg::WAIT_LOAD;
        end else if (st.wait_cnt != 3'd0) begin
            next_st.wait_cnt = st.wait_cnt - 3'd1;
        end

        for (int a = 0; a < aqb_pkg::AXES; a++) begin
            next_st.axis[a].start = 1'b0;
            next_st.axis[a].stop = 1'b0;
            evt_set = 1'b0;

            // ****************************************
            // move completion and error stop
            // ****************************************
            if (axis_in[a].error_stop) begin
                next_st.axis[a].fill = aqb_pkg::FILL_NONE;
            end else if (axis_in[a].move_done) begin
                case (st.axis[a].fill)
                    aqb_pkg::FILL_TWO: begin
                        next_st.axis[a].work = load_ops(st.axis[a].work, st.axis[a].q1);
                        next_st.axis[a].q1 = st.axis[a].q2;
                        next_st.axis[a].fill = aqb_pkg::FILL_ONE;
                        next_st.axis[a].start = 1'b1;
                        evt_set = st.axis[a].work[aqb_pkg::IDX_IRQ_CAUSE][aqb_pkg::NEXT_OP_IRQ_BIT];
                    end
                    aqb_pkg::FILL_ONE: begin
                        next_st.axis[a].work = load_ops(st.axis[a].work, st.axis[a].q1);
                        next_st.axis[a].fill = aqb_pkg::FILL_WORK;
                        next_st.axis[a].start = 1'b1;
                    end
                    aqb_pkg::FILL_WORK: next_st.axis[a].fill = aqb_pkg::FILL_NONE;
                    default: next_st.axis[a].fill = st.axis[a].fill;
                endcase
            end

            // ****************************************
            // host commands
            // ****************************************
            sel = accept && cmd_in.axis == 2'(a);
            if (sel && is_wr_work) begin
                wi = wr_work_off[5:0];
                if (wi == aqb_pkg::IDX_EVT_STATUS) begin
                    // write one to clear
                    next_st.axis[a].work[wi] = st.axis[a].work[wi] & ~(cmd_in.data & aqb_pkg::reg_mask(wi));
                end else if (aqb_pkg::writable(wi)) begin
                    // goes straight to the running move, bypassing the queue
                    next_st.axis[a].work[wi] = cmd_in.data & aqb_pkg::reg_mask(wi);
                end
            end
            if (sel && is_wr_pre) begin
                pi = wr_pre_off[3:0];
                if (pi == aqb_pkg::PRE_CMP5) begin
                    // comparator five staging stands apart from the move queue
                    next_st.axis[a].stage[pi] = cmd_in.data;
                end else if (st.axis[a].fill != aqb_pkg::FILL_TWO) begin
                    // staging only; working set and queue untouched until start
                    next_st.axis[a].stage[pi] = cmd_in.data & aqb_pkg::reg_mask(aqb_pkg::pre_to_work(pi));
                end
            end
            if (sel && cmd_in.code == aqb_pkg::CMD_START) begin
                // staging persists, so unwritten parameters carry over
                case (next_st.axis[a].fill)
                    aqb_pkg::FILL_NONE: begin
                        next_st.axis[a].work = load_ops(next_st.axis[a].work, next_st.axis[a].stage);
                        next_st.axis[a].fill = aqb_pkg::FILL_WORK;
                        next_st.axis[a].start = 1'b1;
                    end
                    aqb_pkg::FILL_WORK: begin
                        next_st.axis[a].q1 = next_st.axis[a].stage;
                        next_st.axis[a].fill = aqb_pkg::FILL_ONE;
                    end
                    aqb_pkg::FILL_ONE: begin
                        next_st.axis[a].q2 = next_st.axis[a].stage;
                        next_st.axis[a].fill = aqb_pkg::FILL_TWO;
                    end
                    default: next_st.axis[a].fill = next_st.axis[a].fill;
                endcase
            end
            if (sel && cmd_in.code == aqb_pkg::CMD_PRE_CANCEL) begin
                next_st.axis[a].cancel_armed = 1'b1;
            end
            if (sel && is_stop) begin
                next_st.axis[a].stop = 1'b1;
                if (st.axis[a].cancel_armed) begin
                    next_st.axis[a].cancel_armed = 1'b0;
                    // the running set stays until the stop takes effect
                    if (next_st.axis[a].fill != aqb_pkg::FILL_NONE) begin
                        next_st.axis[a].fill = aqb_pkg::FILL_WORK;
                    end
                end
            end
            if (sel && (is_rd_work || is_rd_pre)) begin
                next_st.rd_valid = 1'b1;
                if (is_rd_work) begin
                    next_st.rd_data = read_work(st.axis[a], axis_in[a], rd_work_off[5:0]);
                end else begin
                    next_st.rd_data = st.axis[a].stage[rd_pre_off[3:0]];
                end
            end

            // set wins over a clear in the same cycle
            if (evt_set) begin
                next_st.axis[a].work[aqb_pkg::IDX_EVT_STATUS][aqb_pkg::NEXT_OP_EVT_BIT] = 1'b1;
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    logic [aqb_pkg::AXES-1:0] evt_pending;

    for (genvar a = 0; a < aqb_pkg::AXES; a++) begin : g_axis
        for (genvar i = 0; i < aqb_pkg::PRE; i++) begin : g_op
            assign axis_out[a].op_work[i] = st.axis[a].work[aqb_pkg::pre_to_work(4'(i))];
        end
        // pulse completion can chain moves only fifteen clocks apart
        assign axis_out[a].completion_timing_select =
            st.axis[a].work[aqb_pkg::IDX_MODE][aqb_pkg::COMPLETION_SEL_BIT];
        assign axis_out[a].queue_fill_level = st.axis[a].fill;
        assign axis_out[a].queue_full_flag = st.axis[a].fill == aqb_pkg::FILL_TWO;
        assign axis_out[a].start = st.axis[a].start;
        assign axis_out[a].stop = st.axis[a].stop;
        assign evt_pending[a] = st.axis[a].work[aqb_pkg::IDX_EVT_STATUS][aqb_pkg::NEXT_OP_EVT_BIT];
    end

    assign rd_data_out = st.rd_data;
    assign rd_valid_out = st.rd_valid;
    assign wait_request_n_out = st.wait_cnt == 3'd0;
    assign int_n_out = ~(|evt_pending);

endmodule

// >>> bench/aqb_axis_bank_checker.sv
// concurrent checks on the command port and operation queue of the register bank
`timescale 1ns/1ps

module aqb_axis_bank_checker (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire aqb_pkg::aqb_cmd_t cmd_in,
    input wire aqb_pkg::aqb_axis_in_t [aqb_pkg::AXES-1:0] axis_in,
    input wire aqb_pkg::aqb_axis_out_t [aqb_pkg::AXES-1:0] axis_out,
    input wire logic [31:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic wait_request_n_out,
    input wire logic int_n_out
);
    // ****************************************
    // helpers
    // ****************************************
    logic take;
    logic take0;
    logic quiet0;
    logic [1:0] fill0;
    logic done_any;
    assign take = cmd_in.valid && wait_request_n_out;
    assign take0 = take && cmd_in.axis == 2'd0;
    assign quiet0 = !axis_in[0].move_done && !axis_in[0].error_stop;
    assign fill0 = axis_out[0].queue_fill_level;
    always_comb begin
        done_any = 1'b0;
        for (int i = 0; i < aqb_pkg::AXES; i++) begin
            done_any = done_any | axis_in[i].move_done;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    // ****************************************
    // assertions
    // ****************************************
    property p_wait;
        take |=> !wait_request_n_out [*4] ##1 wait_request_n_out;
    endproperty
    a_wait: assert property (p_wait) else $error("wait window length wrong");
    property p_rd;
        take && cmd_in.code >= aqb_pkg::CMD_RD_WORK_BASE |=> rd_valid_out ##1 !rd_valid_out;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer missing or too long");
    property p_full;
        axis_out[0].queue_full_flag == (fill0 == aqb_pkg::FILL_TWO)
            && axis_out[1].queue_full_flag == (axis_out[1].queue_fill_level == aqb_pkg::FILL_TWO);
    endproperty
    a_full: assert property (p_full) else $error("full flag disagrees with fill level");
    property p_start_empty;
        take0 && cmd_in.code == aqb_pkg::CMD_START && fill0 == aqb_pkg::FILL_NONE && quiet0
            |=> fill0 == aqb_pkg::FILL_WORK && axis_out[0].start;
    endproperty
    a_start_empty: assert property (p_start_empty) else $error("start from empty failed");
    property p_done_shift;
        axis_in[0].move_done && !axis_in[0].error_stop && fill0 == aqb_pkg::FILL_ONE && !take0
            |=> fill0 == aqb_pkg::FILL_WORK && axis_out[0].start ##1 !axis_out[0].start;
    endproperty
    a_done_shift: assert property (p_done_shift) else $error("queued entry not auto started");
    property p_err;
        axis_in[0].error_stop && !take0 |=> fill0 == aqb_pkg::FILL_NONE;
    endproperty
    a_err: assert property (p_err) else $error("error stop kept queue");
    property p_full_ignore;
        take0 && cmd_in.code == aqb_pkg::CMD_START && fill0 == aqb_pkg::FILL_TWO && quiet0
            |=> fill0 == aqb_pkg::FILL_TWO && !axis_out[0].start;
    endproperty
    a_full_ignore: assert property (p_full_ignore) else $error("start accepted while full");
    property p_pre_hold;
        take0 && cmd_in.code == aqb_pkg::CMD_WR_PRE_BASE && fill0 != aqb_pkg::FILL_NONE && quiet0
            |=> $stable(axis_out[0].op_work);
    endproperty
    a_pre_hold: assert property (p_pre_hold) else $error("queued write changed working set");
    property p_wr_work;
        take0 && cmd_in.code == aqb_pkg::CMD_WR_WORK_BASE && quiet0
            |=> axis_out[0].op_work[0] == $past(cmd_in.data);
    endproperty
    a_wr_work: assert property (p_wr_work) else $error("working write not immediate");
    property p_int;
        $fell(int_n_out) |-> $past(done_any) || $past(done_any, 2);
    endproperty
    a_int: assert property (p_int) else $error("interrupt without move completion");
    property p_stop;
        take0 && (cmd_in.code == aqb_pkg::CMD_STOP_DECEL || cmd_in.code == aqb_pkg::CMD_STOP_IMMED)
            |=> axis_out[0].stop ##1 !axis_out[0].stop;
    endproperty
    a_stop: assert property (p_stop) else $error("stop pulse missing or too long");
endmodule

// >>> bench/aqb_host_model.sv
// host side model issuing commands and collecting read answers
`timescale 1ns/1ps

module aqb_host_model (
    input wire logic clk_in,
    input wire logic wait_request_n_in,
    input wire logic rd_valid_in,
    input wire logic [31:0] rd_data_in,
    output aqb_pkg::aqb_cmd_t cmd_out
);
    initial cmd_out = '0;

    // full-queue writes come from refusal cases, the comparator five staging case and the second cancel-and-stop pass
    task automatic issue(input logic [1:0] ax, input logic [7:0] c, input logic [31:0] d,
                         output logic [31:0] q, output logic rv, output logic ok);
        int n;
        n = 0;
        @(posedge clk_in);
        cmd_out <= '{valid: 1'b1, axis: ax, code: c, data: d};
        // held until a taken edge, so the gap after each command is kept
        do begin
            @(posedge clk_in);
            n++;
        end while (wait_request_n_in !== 1'b1 && n < 40);
        ok = wait_request_n_in === 1'b1;
        cmd_out.valid <= 1'b0;
        @(posedge clk_in);
        q = rd_data_in;
        rv = rd_valid_in;
    endtask
endmodule

// >>> bench/aqb_axis_bank_tb.sv
// self-checking testbench for the axis register bank
`timescale 1ns/1ps

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module aqb_axis_bank_tb;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    aqb_pkg::aqb_cmd_t cmd;
    aqb_pkg::aqb_axis_in_t [aqb_pkg::AXES-1:0] axis_in;
    aqb_pkg::aqb_axis_out_t [aqb_pkg::AXES-1:0] axis_out;
    logic [31:0] rd_data;
    logic rd_valid;
    logic wait_n;
    logic int_n;
    logic [7:0] stops [2] = '{8'h49, 8'h4A};
    int err_total = 0;
    int samples_checked = 0;

    always #2 clk_in = ~clk_in;

    aqb_host_model host (.clk_in(clk_in), .wait_request_n_in(wait_n), .rd_valid_in(rd_valid),
        .rd_data_in(rd_data), .cmd_out(cmd));
    aqb_axis_bank DUT (.clk_in(clk_in), .resetn_in(resetn_in), .cmd_in(cmd), .axis_in(axis_in),
        .axis_out(axis_out), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .wait_request_n_out(wait_n), .int_n_out(int_n));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************
    // access tasks
    // ****************************************
    task automatic op(input logic [1:0] ax, input logic [7:0] c, input logic [31:0] d,
                      output logic [31:0] q, output logic rv);
        logic ok;
        host.issue(ax, c, d, q, rv, ok);
        if (ok !== 1'b1) begin
            err_total++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [1:0] ax, input logic [7:0] c, input logic [31:0] d);
        logic [31:0] q;
        logic rv;
        op(ax, c, d, q, rv);
    endtask
    task automatic rd(input logic [1:0] ax, input logic [7:0] c, input logic [31:0] exp);
        logic [31:0] q;
        logic rv;
        op(ax, c, 32'h0000_0000, q, rv);
        `CHK(rv, 1'b1)
        `CHK(q, exp)
    endtask
    // levels are looked at on the falling edge, well clear of updates
    task automatic lvl(input logic [1:0] ax, input logic [1:0] f);
        @(negedge clk_in);
        `CHK(axis_out[ax].queue_fill_level, f)
        `CHK(axis_out[ax].queue_full_flag, f == 2'b11)
    endtask
    task automatic pulse(input logic [1:0] ax, input logic err);
        @(posedge clk_in);
        axis_in[ax].move_done <= !err;
        axis_in[ax].error_stop <= err;
        @(posedge clk_in);
        axis_in[ax].move_done <= 1'b0;
        axis_in[ax].error_stop <= 1'b0;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        axis_in = '0;
        axis_in[0].cmd_latch = 32'hA5A5_0001;
        axis_in[0].defl_latch = 16'h0BCD;
        axis_in[0].ext_status = 24'hFF_FFFF;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        rd(2'd0, 8'hD0, 32'h0000_0000);
        lvl(2'd0, 2'b00);
        wr(2'd0, 8'h91, 32'hFFFF_1234);
        rd(2'd0, 8'hD1, 32'h0000_1234);
        wr(2'd0, 8'h90, 32'h8765_4321);
        rd(2'd0, 8'hD0, 32'h8765_4321);
        wr(2'd0, 8'h98, 32'hFEDC_BA98);
        rd(2'd0, 8'hD8, 32'hFEDC_BA98);
        rd(2'd1, 8'hD0, 32'h0000_0000);
        wr(2'd0, 8'hAD, 32'h0000_0000);
        rd(2'd0, 8'hED, 32'hA5A5_0001);
        rd(2'd0, 8'hEF, 32'h0000_0BCD);
        $display("test registers done");
        wr(2'd0, 8'hAC, 32'h0000_0020);
        wr(2'd0, 8'h80, 32'h0000_0011);
        lvl(2'd0, 2'b00);
        `CHK(axis_out[0].op_work[0], 32'h8765_4321)
        wr(2'd0, 8'h51, 32'h0000_0000);
        lvl(2'd0, 2'b01);
        `CHK(axis_out[0].op_work[0], 32'h0000_0011)
        `CHK(axis_out[0].completion_timing_select, 1'b0)
        wr(2'd0, 8'h80, 32'h0000_0022);
        wr(2'd0, 8'h87, 32'h0000_0040);
        wr(2'd0, 8'h51, 32'h0000_0000);
        lvl(2'd0, 2'b10);
        `CHK(axis_out[0].op_work[0], 32'h0000_0011)
        wr(2'd0, 8'h80, 32'h0000_0033);
        wr(2'd0, 8'h51, 32'h0000_0000);
        lvl(2'd0, 2'b11);
        rd(2'd0, 8'hF1, 32'h00FF_FFFF);
        wr(2'd0, 8'h80, 32'h0000_0044);
        wr(2'd0, 8'h51, 32'h0000_0000);
        lvl(2'd0, 2'b11);
        rd(2'd0, 8'hC0, 32'h0000_0033);
        wr(2'd0, 8'h8B, 32'h0000_0055);
        rd(2'd0, 8'hCB, 32'h0000_0055);
        pulse(2'd0, 1'b0);
        lvl(2'd0, 2'b10);
        `CHK(axis_out[0].op_work[0], 32'h0000_0022)
        `CHK(axis_out[0].op_work[11], 32'h0000_0000)
        `CHK(axis_out[0].completion_timing_select, 1'b1)
        `CHK(int_n, 1'b0)
        rd(2'd0, 8'hF1, 32'h00FE_FFFF);
        wr(2'd0, 8'hB3, 32'h0000_0020);
        lvl(2'd0, 2'b10);
        `CHK(int_n, 1'b1)
        pulse(2'd0, 1'b0);
        lvl(2'd0, 2'b01);
        `CHK(axis_out[0].op_work[0], 32'h0000_0033)
        `CHK(axis_out[0].completion_timing_select, 1'b1)
        pulse(2'd0, 1'b0);
        lvl(2'd0, 2'b00);
        $display("test queue done");
        foreach (stops[i]) begin
            wr(2'd0, 8'h51, 32'h0000_0000);
            wr(2'd0, 8'h51, 32'h0000_0000);
            wr(2'd0, 8'h26, 32'h0000_0000);
            wr(2'd0, stops[i], 32'h0000_0000);
            lvl(2'd0, 2'b01);
        end
        wr(2'd0, 8'h51, 32'h0000_0000);
        lvl(2'd0, 2'b10);
        pulse(2'd0, 1'b1);
        lvl(2'd0, 2'b00);
        lvl(2'd1, 2'b00);
        $display("test cancel done");
        give_verdict();
    end
endmodule

bind aqb_axis_bank aqb_axis_bank_checker u_checker (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .cmd_in(cmd_in),
    .axis_in(axis_in),
    .axis_out(axis_out),
    .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out),
    .wait_request_n_out(wait_request_n_out),
    .int_n_out(int_n_out)
);
